// ==== seq_status_pkg.sv ====
// Purpose: Shared constants and types for the target sequence status block
// Assumes: One 125 MHz clock, asynchronous active-low reset
// Notes:   Interrupt status values are full bytes as reported to the host
`default_nettype none
package seq_status_pkg;

  // ==========================================================
  // Sequence commands
  typedef enum logic [1:0] {
    CMD_SEL_NOATN = 2'b00,
    CMD_SEL_ATN   = 2'b01,
    CMD_RECV      = 2'b10,
    CMD_DISC      = 2'b11
  } seq_cmd_t;

  // ==========================================================
  // Events from the bus sequencer, same clock domain
  typedef struct packed {
    logic       msg_rx;      // Message-out byte received
    logic [7:0] msg_data;    // That byte
    logic       msg_bad;     // Parity error or invalid identify on it
    logic       halt;        // Sequence stops before command phase
    logic       cmd_go;      // Command phase begins
    logic       cdb_done;    // Last command byte received
    logic       cmd_parity;  // Parity error during command phase
    logic       msg_tx;      // Disconnect message byte sent
    logic       bus_free;    // Bus released to free state
  } seq_ev_t;

  // ==========================================================
  // Interrupt status values
  localparam logic [7:0] IST_NONE    = 8'h00;
  localparam logic [7:0] IST_SEL     = 8'h01;
  localparam logic [7:0] IST_SEL_A   = 8'h11;
  localparam logic [7:0] IST_SATN    = 8'h02;
  localparam logic [7:0] IST_SATN_A  = 8'h12;
  localparam logic [7:0] IST_SERV    = 8'h08;
  localparam logic [7:0] IST_SERV_A  = 8'h18;
  localparam logic [7:0] IST_DISC    = 8'h28;

  // ==========================================================
  // Sequence step values and counts
  localparam logic [2:0] STEP_0      = 3'h0;
  localparam logic [2:0] STEP_1      = 3'h1;
  localparam logic [2:0] STEP_2      = 3'h2;
  localparam logic [2:0] STEP_4      = 3'h4;
  localparam logic [2:0] STEP_5      = 3'h5;
  localparam logic [2:0] STEP_6      = 3'h6;
  localparam logic [7:0] NULL_MSG    = 8'h00;
  localparam logic [1:0] LAST_MSG2   = 2'h2;   // Index of third message byte
  localparam logic [1:0] MSG_CNT_RST = 2'h0;

endpackage : seq_status_pkg
`default_nettype wire

// ==== seq_sync2.sv ====
// Purpose: Two-flop synchroniser for pin levels
// Assumes: Input is a slowly changing level
// Notes:   First stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none
module seq_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;

  if (WIDTH < 1) begin : g_chk
    $error("seq_sync2 width must be at least one");
  end

  // ==========================================================
  // Two stages
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : seq_sync2
`default_nettype wire

// ==== seq_step_reg.sv ====
// Purpose: Holds the 3-bit sequence step field
// Assumes: Load and clear are one-cycle strobes
// Notes:   Load wins over clear
`timescale 1ns/100ps
`default_nettype none
module seq_step_reg
  import seq_status_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       clr,
  input  wire logic       ld,
  input  wire logic [2:0] ld_val,
  output logic      [2:0] q
);
  // ==========================================================
  // Step register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= STEP_0;
    end else if (ld) begin
      q <= ld_val;
    end else if (clr) begin
      q <= STEP_0;
    end
  end
endmodule : seq_step_reg
`default_nettype wire

// ==== seq_status.sv ====
// Purpose: Tracks target-mode sequences and reports step and status
// Assumes: Events come from same-clock logic; ATN arrives from the pin
// Notes:   Status and step hold until the next sequence start
`timescale 1ns/100ps
`default_nettype none
module seq_status
  import seq_status_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  input  wire logic                      start,
  input  wire seq_status_pkg::seq_cmd_t  seq_cmd,
  input  wire logic                      scsi2_en,
  input  wire logic [7:0]                bus_id,
  input  wire seq_status_pkg::seq_ev_t   ev,
  input  wire logic                      atn_n,
  output logic [2:0]                     seq_step_q,
  output logic [7:0]                     int_status_q,
  output logic                           done_q,
  output logic                           busy_q,
  output logic                           fifo_wr_q,
  output logic [7:0]                     fifo_data_q
);
  import seq_status_pkg::*;

  // ==========================================================
  // States
  typedef enum logic [2:0] {
    ST_IDLE      = 3'b000,
    ST_LOAD_ID   = 3'b001,
    ST_LOAD_NULL = 3'b010,
    ST_WAIT_CMD  = 3'b011,
    ST_MSG       = 3'b100,
    ST_CMD       = 3'b101,
    ST_DISC      = 3'b110,
    ST_FREE      = 3'b111
  } state_t;

  state_t     state_q, state_d;
  seq_cmd_t   cmd_q;
  logic       scsi2_q;
  logic [7:0] bus_id_q;
  logic       atn_s;
  logic       atn_seen_q, atn_seen_d;
  logic [1:0] msg_cnt_q, msg_cnt_d;
  logic       tx_cnt_q, tx_cnt_d;
  logic       step_clr, step_ld;
  logic [2:0] step_val;
  logic       fin;
  logic [7:0] fin_ist;
  logic       fifo_wr_d;
  logic [7:0] fifo_data_d;

  // ==========================================================
  // ATN pin synchroniser, active low on the bus
  seq_sync2 #(.WIDTH(1)) u_atn_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .d       (~atn_n),
    .q       (atn_s)
  );

  // ==========================================================
  // Step field
  seq_step_reg u_step (
    .clk     (clk),
    .reset_n (reset_n),
    .clr     (step_clr),
    .ld      (step_ld),
    .ld_val  (step_val),
    .q       (seq_step_q)
  );

  // ==========================================================
  // Decodes
  wire        go        = (state_q == ST_IDLE) && start;
  wire        in_cmd    = (state_q == ST_CMD);
  wire        atn_now   = atn_seen_q | atn_s;
  wire        sel_scsi2 = (cmd_q == CMD_SEL_ATN) && scsi2_q;
  wire        last_msg  = !scsi2_q || (msg_cnt_q == LAST_MSG2);
  wire [2:0]  cmd_step  = sel_scsi2 ? STEP_5 : STEP_1;
  wire [2:0]  done_step = sel_scsi2 ? STEP_6 : STEP_2;
  wire [2:0]  msg_step  = scsi2_q ? STEP_4 : STEP_0;

  // Command-phase status by sequence and ATN
  wire [7:0]  ist_sel   = atn_now ? IST_SEL_A : IST_SEL;
  wire [7:0]  ist_satn  = atn_now ? IST_SATN_A : IST_SATN;
  wire [7:0]  ist_recv  = atn_now ? IST_SERV_A : IST_SERV;
  wire [7:0]  ist_cmd   = (cmd_q == CMD_SEL_NOATN) ? ist_sel :
                          (cmd_q == CMD_SEL_ATN) ? ist_satn : ist_recv;

  // ATN seen during command phase, held until next start
  assign atn_seen_d = go ? 1'b0 : (atn_seen_q | (in_cmd & atn_s));

  // ==========================================================
  // Sequence control
  always_comb begin
    state_d     = state_q;
    step_clr    = 1'b0;
    step_ld     = 1'b0;
    step_val    = STEP_0;
    fin         = 1'b0;
    fin_ist     = IST_NONE;
    fifo_wr_d   = 1'b0;
    fifo_data_d = bus_id_q;
    msg_cnt_d   = msg_cnt_q;
    tx_cnt_d    = tx_cnt_q;
    unique case (state_q)
      ST_IDLE: begin
        if (start) begin
          step_clr  = 1'b1;
          msg_cnt_d = MSG_CNT_RST;
          tx_cnt_d  = 1'b0;
          unique case (seq_cmd)
            CMD_SEL_NOATN, CMD_SEL_ATN: state_d = ST_LOAD_ID;
            CMD_RECV: begin
              step_ld  = 1'b1;
              step_val = STEP_1;
              state_d  = ST_CMD;
            end
            CMD_DISC: state_d = ST_DISC;
          endcase
        end
      end
      ST_LOAD_ID: begin
        fifo_wr_d = 1'b1;
        state_d   = (cmd_q == CMD_SEL_ATN) ? ST_MSG : ST_LOAD_NULL;
      end
      ST_LOAD_NULL: begin
        fifo_wr_d   = 1'b1;
        fifo_data_d = NULL_MSG;
        state_d     = ST_WAIT_CMD;
      end
      ST_WAIT_CMD: begin
        if (ev.halt) begin
          fin     = 1'b1;
          fin_ist = IST_SEL;
        end else if (ev.cmd_go) begin
          step_ld  = 1'b1;
          step_val = STEP_1;
          state_d  = ST_CMD;
        end
      end
      ST_MSG: begin
        if (ev.msg_rx) begin
          fifo_wr_d   = 1'b1;
          fifo_data_d = ev.msg_data;
          msg_cnt_d   = msg_cnt_q + 2'h1;
          if (ev.msg_bad) begin
            fin     = 1'b1;
            fin_ist = IST_SATN;
          end else if (last_msg && atn_s) begin
            step_ld  = 1'b1;
            step_val = msg_step;
            fin      = 1'b1;
            fin_ist  = IST_SATN_A;
          end else if (last_msg) begin
            step_ld  = 1'b1;
            step_val = cmd_step;
            state_d  = ST_CMD;
          end
        end
      end
      ST_CMD: begin
        if (ev.cmd_parity) begin
          fin     = 1'b1;
          fin_ist = ist_cmd;
        end else if (ev.cdb_done) begin
          step_ld  = 1'b1;
          step_val = done_step;
          fin      = 1'b1;
          fin_ist  = ist_cmd;
        end
      end
      ST_DISC: begin
        if (ev.msg_tx) begin
          tx_cnt_d = 1'b1;
          if (tx_cnt_q) begin
            step_ld  = 1'b1;
            step_val = STEP_1;
          end
          if (atn_s) begin
            fin     = 1'b1;
            fin_ist = IST_SERV_A;
          end else if (tx_cnt_q) begin
            state_d = ST_FREE;
          end
        end
      end
      ST_FREE: begin
        if (ev.bus_free) begin
          step_ld  = 1'b1;
          step_val = STEP_2;
          fin      = 1'b1;
          fin_ist  = IST_DISC;
        end
      end
    endcase
    if (fin) begin
      state_d = ST_IDLE;
    end
  end

  // ==========================================================
  // Sequence registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q    <= ST_IDLE;
      cmd_q      <= CMD_SEL_NOATN;
      scsi2_q    <= 1'b0;
      bus_id_q   <= 8'h00;
      atn_seen_q <= 1'b0;
      msg_cnt_q  <= MSG_CNT_RST;
      tx_cnt_q   <= 1'b0;
    end else begin
      state_q    <= state_d;
      atn_seen_q <= atn_seen_d;
      msg_cnt_q  <= msg_cnt_d;
      tx_cnt_q   <= tx_cnt_d;
      if (go) begin
        cmd_q    <= seq_cmd;
        scsi2_q  <= scsi2_en;
        bus_id_q <= bus_id;
      end
    end
  end

  // ==========================================================
  // Reported outputs
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      int_status_q <= IST_NONE;
      done_q       <= 1'b0;
      busy_q       <= 1'b0;
      fifo_wr_q    <= 1'b0;
      fifo_data_q  <= 8'h00;
    end else begin
      done_q      <= fin;
      busy_q      <= (state_d != ST_IDLE);
      fifo_wr_q   <= fifo_wr_d;
      fifo_data_q <= fifo_data_d;
      if (go) begin
        int_status_q <= IST_NONE;
      end else if (fin) begin
        int_status_q <= fin_ist;
      end
    end
  end

  // ==========================================================
  // Checks
  chk_step_clears: assert property (
    @(posedge clk) disable iff (!reset_n)
    go && (seq_cmd != CMD_RECV) |=> seq_step_q == STEP_0 && int_status_q == IST_NONE)
    else $error("step not cleared at sequence start");

  chk_sel_done: assert property (
    @(posedge clk) disable iff (!reset_n)
    in_cmd && cmd_q == CMD_SEL_NOATN && !ev.cmd_parity && ev.cdb_done && !atn_now
    |=> done_q && seq_step_q == STEP_2 && int_status_q == IST_SEL)
    else $error("select without ATN completion wrong");

  chk_sel_atn_cmd: assert property (
    @(posedge clk) disable iff (!reset_n)
    in_cmd && cmd_q == CMD_SEL_NOATN && !ev.cmd_parity && ev.cdb_done && atn_now
    |=> seq_step_q == STEP_2 && int_status_q == IST_SEL_A)
    else $error("select completion with ATN wrong");

  chk_sel_parity: assert property (
    @(posedge clk) disable iff (!reset_n)
    in_cmd && cmd_q == CMD_SEL_NOATN && ev.cmd_parity && !atn_now
    |=> seq_step_q == STEP_1 && int_status_q == IST_SEL && !busy_q)
    else $error("select parity halt wrong");

  chk_id_null_load: assert property (
    @(posedge clk) disable iff (!reset_n)
    state_q == ST_LOAD_ID && cmd_q == CMD_SEL_NOATN
    |=> fifo_wr_q && fifo_data_q == bus_id_q ##1 fifo_wr_q && fifo_data_q == NULL_MSG)
    else $error("bus id and null message not loaded");

  chk_msg_atn: assert property (
    @(posedge clk) disable iff (!reset_n)
    state_q == ST_MSG && ev.msg_rx && !ev.msg_bad && !scsi2_q && atn_s
    |=> seq_step_q == STEP_0 && int_status_q == IST_SATN_A && done_q)
    else $error("ATN after first message not reported");

  chk_msg_bad: assert property (
    @(posedge clk) disable iff (!reset_n)
    state_q == ST_MSG && msg_cnt_q == MSG_CNT_RST && ev.msg_rx && ev.msg_bad
    |=> seq_step_q == STEP_0 && int_status_q == IST_SATN && fifo_wr_q)
    else $error("bad first message not reported");

  chk_scsi2_done: assert property (
    @(posedge clk) disable iff (!reset_n)
    in_cmd && sel_scsi2 && !ev.cmd_parity && ev.cdb_done && !atn_now
    |=> seq_step_q == STEP_6 && int_status_q == IST_SATN)
    else $error("three-byte selection completion wrong");

  chk_recv_parity: assert property (
    @(posedge clk) disable iff (!reset_n)
    in_cmd && cmd_q == CMD_RECV && ev.cmd_parity && atn_now
    |=> seq_step_q == STEP_1 && $rose(done_q) && int_status_q == IST_SERV_A)
    else $error("receive parity halt with ATN wrong");

  chk_disc_one: assert property (
    @(posedge clk) disable iff (!reset_n)
    state_q == ST_DISC && ev.msg_tx && !tx_cnt_q && atn_s
    |=> seq_step_q == STEP_0 && int_status_q == IST_SERV_A)
    else $error("disconnect halt after one byte wrong");

  chk_disc_free: assert property (
    @(posedge clk) disable iff (!reset_n)
    state_q == ST_FREE && ev.bus_free
    |=> seq_step_q == STEP_2 && int_status_q == IST_DISC ##1 !done_q)
    else $error("disconnect completion wrong");

endmodule : seq_status
`default_nettype wire

// ==== initiator_model.sv ====
// Purpose: Initiator-side model that raises sequencer events and drives ATN
// Assumes: Called from the bench just after a rising clock edge
// Notes:   Message data shows the inverse of the last byte when not valid
`timescale 1ns/100ps
`default_nettype none
module initiator_model
  import seq_status_pkg::*;
(
  input  wire logic                    clk,
  output var  seq_status_pkg::seq_ev_t ev,
  output var  logic                    atn_n
);
  // ==========================================================
  // Idle bus: no events, ATN released
  initial begin
    ev    = '0;
    atn_n = 1'b1;
  end

  // One-cycle event; codes 0 msg, 1 bad msg, 2 halt, 3 cmd go, 4 cdb, 5 parity, 6 tx, 7 free
  task automatic pulse(input logic [3:0] e, input logic [7:0] d);
    ev.msg_rx     = (e <= 4'h1);
    ev.msg_bad    = (e == 4'h1);
    ev.msg_data   = d;
    ev.halt       = (e == 4'h2);
    ev.cmd_go     = (e == 4'h3);
    ev.cdb_done   = (e == 4'h4);
    ev.cmd_parity = (e == 4'h5);
    ev.msg_tx     = (e == 4'h6);
    ev.bus_free   = (e == 4'h7);
    @(posedge clk);
    #1;
    ev          = '0;
    ev.msg_data = ~d;  // Stale data never repeats the last byte
  endtask : pulse

  // ATN pin level, low asserts; only this model drives the pin
  task automatic set_atn(input logic level);
    atn_n = level;
  endtask : set_atn
endmodule : initiator_model
`default_nettype wire

// ==== seq_status_bench.sv ====
// Purpose: Self-checking bench for the target sequence status block
// Assumes: Inputs change 1 ns after the rising clock edge
// Notes:   Each scenario is one table line: command, option, ATN point, events
`timescale 1ns/100ps
`default_nettype none
module seq_status_bench;
  import seq_status_pkg::*;
  logic       clk;
  logic       reset_n;
  logic       start;
  seq_cmd_t   seq_cmd;
  logic       scsi2_en;
  logic [7:0] bus_id;
  seq_ev_t    ev;
  logic       atn_n;
  logic [2:0] seq_step_q;
  logic [7:0] int_status_q;
  logic       done_q;
  logic       busy_q;
  logic       fifo_wr_q;
  logic [7:0] fifo_data_q;
  logic [7:0] got_q[$];
  int         error_cnt = 0;
  int         check_count = 0;

  seq_status seq_status_i (.clk(clk), .reset_n(reset_n), .start(start), .seq_cmd(seq_cmd),
    .scsi2_en(scsi2_en), .bus_id(bus_id), .ev(ev), .atn_n(atn_n), .seq_step_q(seq_step_q),
    .int_status_q(int_status_q), .done_q(done_q), .busy_q(busy_q), .fifo_wr_q(fifo_wr_q),
    .fifo_data_q(fifo_data_q));
  initiator_model initiator_model_i (.clk(clk), .ev(ev), .atn_n(atn_n));

  // ==========================================================
  // Clock and FIFO write capture
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (fifo_wr_q === 1'b1) got_q.push_back(fifo_data_q);
  end

  // ==========================================================
  // Compare and reporting tasks
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_byte
  task automatic chk_flag(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : chk_flag
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // One sequence: evs holds 4-bit event codes from the top, F ends the list
  task automatic run(input logic [1:0] cmd, input logic s2, input int atn_at, input logic [31:0] evs,
                     input logic [2:0] stp, input logic [7:0] st);
    int         i;
    int         w;
    logic [3:0] e;
    logic [7:0] exp_q[$];
    got_q.delete();
    seq_cmd  = seq_cmd_t'(cmd);
    scsi2_en = s2;
    bus_id   = 8'h5A;
    start    = 1'b1;
    tick(1);
    start = 1'b0;
    tick(1);
    chk_flag(busy_q, 1'b1, "busy");
    chk_byte(int_status_q, 8'h00, "status at start");
    chk_byte({5'h0, seq_step_q}, (cmd == 2'h2) ? 8'h01 : 8'h00, "step at start");
    seq_cmd = CMD_DISC;
    start   = 1'b1;  // Refused while busy
    tick(1);
    start = 1'b0;
    tick(2);
    if (cmd <= 2'h1) exp_q.push_back(8'h5A);
    if (cmd == 2'h0) exp_q.push_back(8'h00);
    for (i = 0; i < 8; i++) begin
      e = evs[31-4*i -: 4];
      if (e == 4'hF) break;
      if (i > 0) tick(1);
      if (i == atn_at) begin
        initiator_model_i.set_atn(1'b0);
        tick(3);
      end
      if (e <= 4'h1 && cmd == 2'h1) exp_q.push_back(8'hC0 + 8'(i));
      initiator_model_i.pulse(e, 8'hC0 + 8'(i));
    end
    w = 0;
    while (done_q !== 1'b1 && w < 50) begin
      tick(1);
      w++;
    end
    chk_flag(done_q, 1'b1, "done");
    chk_flag(busy_q, 1'b0, "busy at done");
    chk_byte({5'h0, seq_step_q}, {5'h0, stp}, "step");
    chk_byte(int_status_q, st, "status");
    tick(2);
    chk_byte(int_status_q, st, "status hold");
    chk_byte(8'(got_q.size()), 8'(exp_q.size()), "fifo count");
    for (i = 0; i < exp_q.size() && i < got_q.size(); i++) chk_byte(got_q[i], exp_q[i], "fifo byte");
    initiator_model_i.set_atn(1'b1);
    tick(3);
  endtask : run

  // ==========================================================
  // Watchdog
  initial begin
    #100000;
    error_cnt++;
    $display("BAD %0t watchdog expired", $time);
    final_report;
  end

  // ==========================================================
  // Main sequence
  initial begin
    reset_n  = 1'b0;
    start    = 1'b0;
    seq_cmd  = CMD_SEL_NOATN;
    scsi2_en = 1'b0;
    bus_id   = 8'h00;
    tick(2);
    reset_n = 1'b1;
    tick(1);
    run(2'h0, 1'b0, 9, 32'h34FF_FFFF, 3'h2, 8'h01);
    run(2'h0, 1'b0, 1, 32'h34FF_FFFF, 3'h2, 8'h11);
    run(2'h0, 1'b0, 9, 32'h35FF_FFFF, 3'h1, 8'h01);
    run(2'h0, 1'b0, 1, 32'h35FF_FFFF, 3'h1, 8'h11);
    run(2'h0, 1'b0, 9, 32'h2FFF_FFFF, 3'h0, 8'h01);
    run(2'h1, 1'b0, 9, 32'h04FF_FFFF, 3'h2, 8'h02);
    run(2'h1, 1'b0, 1, 32'h04FF_FFFF, 3'h2, 8'h12);
    run(2'h1, 1'b0, 9, 32'h05FF_FFFF, 3'h1, 8'h02);
    run(2'h1, 1'b0, 1, 32'h05FF_FFFF, 3'h1, 8'h12);
    run(2'h1, 1'b0, 0, 32'h0FFF_FFFF, 3'h0, 8'h12);
    run(2'h1, 1'b0, 9, 32'h1FFF_FFFF, 3'h0, 8'h02);
    run(2'h1, 1'b1, 9, 32'h1FFF_FFFF, 3'h0, 8'h02);
    run(2'h1, 1'b1, 9, 32'h01FF_FFFF, 3'h0, 8'h02);
    run(2'h1, 1'b1, 9, 32'h0004_FFFF, 3'h6, 8'h02);
    run(2'h1, 1'b1, 9, 32'h0005_FFFF, 3'h5, 8'h02);
    run(2'h1, 1'b1, 3, 32'h0005_FFFF, 3'h5, 8'h12);
    run(2'h1, 1'b1, 2, 32'h000F_FFFF, 3'h4, 8'h12);
    run(2'h2, 1'b0, 9, 32'h4FFF_FFFF, 3'h2, 8'h08);
    run(2'h2, 1'b0, 0, 32'h4FFF_FFFF, 3'h2, 8'h18);
    run(2'h2, 1'b0, 9, 32'h5FFF_FFFF, 3'h1, 8'h08);
    run(2'h2, 1'b0, 0, 32'h5FFF_FFFF, 3'h1, 8'h18);
    run(2'h3, 1'b0, 9, 32'h667F_FFFF, 3'h2, 8'h28);
    run(2'h3, 1'b0, 1, 32'h66FF_FFFF, 3'h1, 8'h18);
    run(2'h3, 1'b0, 0, 32'h6FFF_FFFF, 3'h0, 8'h18);
    final_report;
  end
endmodule : seq_status_bench
`default_nettype wire
